/* hdl/stc_prescaler.v */
// Free-running divider giving one-cycle ticks at the three internal rates
// Assumes the fast clock is the module clock
`timescale 1ns/10ps
`default_nettype none
`include "stc_map.vh"
module stc_prescaler
(
  input wire ref_clk_i,
  input wire rst_b_i,
  output reg tick_div11_o,
  output reg tick_div7_o,
  output reg tick_div3_o
);
  reg [`STC_PRESCALE_W-1:0] count_reg;
  wire [`STC_PRESCALE_W-1:0] count_next;
  assign count_next = count_reg + 11'h001;

  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      count_reg <= 11'h000;
      tick_div11_o <= 1'b0;
      tick_div7_o <= 1'b0;
      tick_div3_o <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      tick_div11_o <= (count_reg == 11'h7ff);
      tick_div7_o <= (count_reg[6:0] == 7'h7f);
      tick_div3_o <= (count_reg[2:0] == 3'h7);
    end
  end
endmodule // stc_prescaler
`default_nettype wire

/* hdl/stc_timer_ctrl.v */
// Control register and staged timer registers of the 16-bit timer
// Assumes byte port, read data one cycle after read strobe
`timescale 1ns/10ps
`default_nettype none
`include "stc_map.vh"
module stc_timer_ctrl
(
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire stop_enter_i,
  input wire timer_pin_i,
  input wire [15:0] up_count_i,
  output reg [7:0] rdata_o,
  output reg [15:0] compare_reg_a_o,
  output reg [15:0] compare_reg_b_o,
  output reg [1:0] operating_mode_sel_o,
  output reg [1:0] start_control_o,
  output reg output_flipflop_ctrl_o,
  output reg capture_single_edge_o,
  output reg trigger_stop_en_o,
  output reg pulse_gen_oneshot_o,
  output reg auto_capture_active_o,
  output reg source_tick_o,
  output reg pin_edge_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  reg [7:0] timer_control_reg;
  reg auto_capture_en_reg;
  reg [7:0] a_lower_reg;
  reg [7:0] b_lower_reg;
  reg [15:0] a_stage_reg;
  reg [15:0] b_stage_reg;
  reg a_pend_reg;
  reg b_pend_reg;
  reg pin_s1_reg;
  reg pin_s2_reg;
  reg pin_s3_reg;
  reg [7:0] timer_control_next;
  wire tick_div11;
  wire tick_div7;
  wire tick_div3;
  wire [1:0] mode;
  wire [1:0] ck_sel;
  wire [1:0] start;
  wire in_ppg;
  wire pin_edge;
  reg src_tick;

  assign mode = timer_control_reg[`STC_BIT_MODE_HI:`STC_BIT_MODE_LO];
  assign ck_sel = timer_control_reg[`STC_BIT_CK_HI:`STC_BIT_CK_LO];
  assign start = timer_control_reg[`STC_BIT_START_HI:`STC_BIT_START_LO];
  assign in_ppg = (mode == `STC_MODE_PPG);
  assign pin_edge = pin_s2_reg ^ pin_s3_reg;

  function wr_hit;
    input [7:0] a;
    input [7:0] want;
    input w;
    begin
      wr_hit = w && (a == want);
    end
  endfunction

  stc_prescaler u_prescaler
  (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .tick_div11_o(tick_div11),
    .tick_div7_o(tick_div7),
    .tick_div3_o(tick_div3)
  );

  // ---------------------------------------------------------------
  // Source clock select
  // ---------------------------------------------------------------
  always @*
  begin
    case (ck_sel)
      `STC_CK_DIV11: src_tick = tick_div11;
      `STC_CK_DIV7: src_tick = tick_div7;
      `STC_CK_DIV3: src_tick = tick_div3;
      default: src_tick = pin_edge;
    endcase
  end

  // ---------------------------------------------------------------
  // Control register next value
  // ---------------------------------------------------------------
  always @*
  begin
    timer_control_next = timer_control_reg;
    if (wr_hit(addr_i, `STC_ADDR_CTRL, wr_i) ||
        wr_hit(addr_i, `STC_ADDR_CTRL_ALIAS, wr_i))
      timer_control_next = wdata_i;
    if (stop_enter_i)
      timer_control_next[`STC_BIT_START_HI:`STC_BIT_START_LO] =
        `STC_START_STOP;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      timer_control_reg <= `STC_CTRL_RESET;
      auto_capture_en_reg <= 1'b0;
      a_lower_reg <= 8'hff;
      b_lower_reg <= 8'hff;
      a_stage_reg <= `STC_TREG_RESET;
      b_stage_reg <= `STC_TREG_RESET;
      a_pend_reg <= 1'b0;
      b_pend_reg <= 1'b0;
      compare_reg_a_o <= `STC_TREG_RESET;
      compare_reg_b_o <= `STC_TREG_RESET;
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
      rdata_o <= 8'h00;
      operating_mode_sel_o <= 2'h0;
      start_control_o <= 2'h0;
      output_flipflop_ctrl_o <= 1'b0;
      capture_single_edge_o <= 1'b0;
      trigger_stop_en_o <= 1'b0;
      pulse_gen_oneshot_o <= 1'b0;
      auto_capture_active_o <= 1'b0;
      source_tick_o <= 1'b0;
      pin_edge_o <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= timer_pin_i;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      timer_control_reg <= timer_control_next;
      // Only the primary address sets capture enable from bit 6
      if (wr_hit(addr_i, `STC_ADDR_CTRL, wr_i))
        auto_capture_en_reg <= wdata_i[`STC_BIT_EDGE];
      if (wr_hit(addr_i, `STC_ADDR_A_LO, wr_i))
        a_lower_reg <= wdata_i;
      if (wr_hit(addr_i, `STC_ADDR_B_LO, wr_i) && in_ppg)
        b_lower_reg <= wdata_i;
      if (wr_hit(addr_i, `STC_ADDR_A_HI, wr_i))
      begin
        a_stage_reg <= {wdata_i, a_lower_reg};
        a_pend_reg <= 1'b1;
      end
      else if (src_tick && a_pend_reg)
      begin
        compare_reg_a_o <= a_stage_reg;
        a_pend_reg <= 1'b0;
      end
      if (wr_hit(addr_i, `STC_ADDR_B_HI, wr_i) && in_ppg)
      begin
        b_stage_reg <= {wdata_i, b_lower_reg};
        b_pend_reg <= 1'b1;
      end
      else if (src_tick && auto_capture_en_reg && !in_ppg &&
               start != `STC_START_STOP)
        compare_reg_b_o <= up_count_i;
      else if (src_tick && b_pend_reg)
      begin
        compare_reg_b_o <= b_stage_reg;
        b_pend_reg <= 1'b0;
      end
      rdata_o <= 8'h00;
      if (rd_i)
      begin
        case (addr_i)
          `STC_ADDR_A_LO: rdata_o <= compare_reg_a_o[7:0];
          `STC_ADDR_A_HI: rdata_o <= compare_reg_a_o[15:8];
          `STC_ADDR_B_LO: rdata_o <= compare_reg_b_o[7:0];
          `STC_ADDR_B_HI: rdata_o <= compare_reg_b_o[15:8];
          `STC_ADDR_CTRL: rdata_o <= timer_control_reg;
          `STC_ADDR_CTRL_ALIAS: rdata_o <= timer_control_reg;
          `STC_ADDR_STAT: rdata_o <= {5'h00, auto_capture_en_reg,
                                      b_pend_reg, a_pend_reg};
          default: rdata_o <= 8'h00;
        endcase
      end
      operating_mode_sel_o <= timer_control_next[1:0];
      start_control_o <= timer_control_next[5:4];
      output_flipflop_ctrl_o <= timer_control_next[`STC_BIT_TFF];
      capture_single_edge_o <= timer_control_next[`STC_BIT_EDGE] &&
        (timer_control_next[1:0] == `STC_MODE_PULSE);
      trigger_stop_en_o <= timer_control_next[`STC_BIT_EDGE] &&
        (timer_control_next[1:0] == `STC_MODE_TIMER);
      pulse_gen_oneshot_o <= timer_control_next[`STC_BIT_EDGE] &&
        (timer_control_next[1:0] == `STC_MODE_PPG);
      auto_capture_active_o <= auto_capture_en_reg && !in_ppg &&
        (start != `STC_START_STOP);
      source_tick_o <= src_tick;
      pin_edge_o <= pin_edge;
    end
  end
endmodule // stc_timer_ctrl
`default_nettype wire

/* pkg/stc_map.vh */
// Register offsets, field positions, reset values and prescaler width
// Assumes a byte-wide register port with one-cycle read latency
`ifndef STC_MAP_VH
`define STC_MAP_VH
`define STC_ADDR_A_LO 8'h10
`define STC_ADDR_A_HI 8'h11
`define STC_ADDR_B_LO 8'h12
`define STC_ADDR_B_HI 8'h13
`define STC_ADDR_CTRL 8'h14
`define STC_ADDR_CTRL_ALIAS 8'h15
`define STC_ADDR_STAT 8'h16
`define STC_CTRL_RESET 8'h00
`define STC_TREG_RESET 16'hffff
`define STC_BIT_TFF 7
`define STC_BIT_EDGE 6
`define STC_BIT_START_HI 5
`define STC_BIT_START_LO 4
`define STC_BIT_CK_HI 3
`define STC_BIT_CK_LO 2
`define STC_BIT_MODE_HI 1
`define STC_BIT_MODE_LO 0
`define STC_MODE_TIMER 2'h0
`define STC_MODE_WINDOW 2'h1
`define STC_MODE_PULSE 2'h2
`define STC_MODE_PPG 2'h3
`define STC_CK_DIV11 2'h0
`define STC_CK_DIV7 2'h1
`define STC_CK_DIV3 2'h2
`define STC_CK_PIN 2'h3
`define STC_START_STOP 2'h0
`define STC_PRESCALE_W 11
`endif

/* testbench/stc_ctrl_props.sv */
// Checker of the control fields and read port of the timer block
// Assumes binding to stc_timer_ctrl on a single clock
`timescale 1ns/10ps
`default_nettype none
`include "stc_map.vh"
module stc_ctrl_props
(
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire stop_enter_i,
  input wire [7:0] rdata_o,
  input wire [1:0] operating_mode_sel_o,
  input wire [1:0] start_control_o,
  input wire output_flipflop_ctrl_o,
  input wire capture_single_edge_o,
  input wire trigger_stop_en_o,
  input wire pulse_gen_oneshot_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire ctrl_wr = wr_i &&
    (addr_i == `STC_ADDR_CTRL || addr_i == `STC_ADDR_CTRL_ALIAS);
  sequence s_ctrl_wr;
    ctrl_wr;
  endsequence
  AST_EDGE_SEL: assert property (s_ctrl_wr |=>
    capture_single_edge_o ==
    ($past(wdata_i[6]) && $past(wdata_i[1:0]) == 2'h2))
    else $error("edge sel");
  AST_TRIG_STOP: assert property (s_ctrl_wr |=>
    trigger_stop_en_o ==
    ($past(wdata_i[6]) && $past(wdata_i[1:0]) == 2'h0))
    else $error("trig stop");
  AST_ONESHOT: assert property (s_ctrl_wr |=>
    pulse_gen_oneshot_o ==
    ($past(wdata_i[6]) && $past(wdata_i[1:0]) == 2'h3))
    else $error("oneshot");
  AST_MODE: assert property (s_ctrl_wr |=>
    operating_mode_sel_o == $past(wdata_i[1:0])) else $error("mode");
  AST_FF: assert property (s_ctrl_wr |=>
    output_flipflop_ctrl_o == $past(wdata_i[7])) else $error("flipflop");
  AST_START: assert property (s_ctrl_wr ##0 !stop_enter_i |=>
    start_control_o == $past(wdata_i[5:4])) else $error("start");
  AST_STOP_CLR: assert property (stop_enter_i |=>
    start_control_o == 2'h0) else $error("stop clear");
  AST_STOP_HOLD: assert property (start_control_o == 2'h0 && !ctrl_wr
    |=> start_control_o == 2'h0) else $error("start hold");
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("rdata idle");
endmodule // stc_ctrl_props
bind stc_timer_ctrl stc_ctrl_props u_props (.ref_clk_i(ref_clk_i),
  .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .stop_enter_i(stop_enter_i), .rdata_o(rdata_o),
  .operating_mode_sel_o(operating_mode_sel_o),
  .start_control_o(start_control_o),
  .output_flipflop_ctrl_o(output_flipflop_ctrl_o),
  .capture_single_edge_o(capture_single_edge_o),
  .trigger_stop_en_o(trigger_stop_en_o),
  .pulse_gen_oneshot_o(pulse_gen_oneshot_o));
`default_nettype wire

/* testbench/stc_timer_ctrl_tb_top.sv */
// Self-checking bench of the timer control block
// Assumes the register map header is on the include path
`timescale 1ns/10ps
`default_nettype none
`include "stc_map.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) \
  begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module stc_timer_ctrl_tb_top;
  logic ref_clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0;
  logic stop_enter_i = 0, timer_pin_i = 0;
  logic [7:0] addr_i = 0, wdata_i = 0, rdata_o;
  logic [15:0] up_count_i = 0, ra, rb;
  logic [1:0] mode, start;
  logic tff, edg, trg, osh, acap, tick, pe;
  int miscompares = 0, cmp_count = 0, n, k;
  always #50 ref_clk_i = ~ref_clk_i;
  stc_timer_ctrl u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .stop_enter_i(stop_enter_i), .timer_pin_i(timer_pin_i),
    .up_count_i(up_count_i), .rdata_o(rdata_o), .compare_reg_a_o(ra),
    .compare_reg_b_o(rb), .operating_mode_sel_o(mode),
    .start_control_o(start), .output_flipflop_ctrl_o(tff),
    .capture_single_edge_o(edg), .trigger_stop_en_o(trg),
    .pulse_gen_oneshot_o(osh), .auto_capture_active_o(acap),
    .source_tick_o(tick), .pin_edge_o(pe));
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1;
    @(posedge ref_clk_i);
    wr_i <= 0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge ref_clk_i);
    addr_i <= a; rd_i <= 1;
    @(posedge ref_clk_i);
    rd_i <= 0;
    #1 `CHK("rdata", e, rdata_o)
  endtask
  task idle(input int c);
    repeat (c) @(posedge ref_clk_i);
    #1;
  endtask
  task wait_tick;
    n = 0;
    do begin @(posedge ref_clk_i); #1 n++; end while (tick !== 1 && n < 5000);
    if (n >= 5000)
    begin
      miscompares++;
      conclude;
    end
  endtask
  initial
  begin
    #5000000 miscompares++;
    conclude;
  end
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1;
    rd(`STC_ADDR_CTRL, `STC_CTRL_RESET);
    `CHK("reg_a", `STC_TREG_RESET, ra)
    `CHK("tff_rst", 1'b0, tff)
    for (k = 0; k < 4; k++)
    begin
      wr(`STC_ADDR_CTRL_ALIAS, 8'h40 | k[1:0]);
      idle(1);
      `CHK("mode", k[1:0], mode)
      `CHK("edge", k == 2, edg)
      `CHK("trig", k == 0, trg)
      `CHK("oneshot", k == 3, osh)
    end
    rd(`STC_ADDR_STAT, 8'h00);
    for (k = 0; k < 3; k++)
    begin
      wr(`STC_ADDR_CTRL, {4'h0, k[1:0], 2'h0});
      wait_tick;
      wait_tick;
      `CHK("tick_gap", 32'd1 << (11 - 4 * k), n)
    end
    wr(`STC_ADDR_CTRL, 8'h0c);
    timer_pin_i <= 1;
    wait_tick;
    `CHK("pin_tick", 1'b1, n < 8)
    `CHK("pin_edge", 1'b1, pe)
    wr(`STC_ADDR_CTRL, 8'h08);
    wr(`STC_ADDR_A_LO, 8'h34);
    idle(20);
    `CHK("a_lo_only", 16'hffff, ra)
    wr(`STC_ADDR_A_HI, 8'h12);
    #1 `CHK("a_staged", 16'hffff, ra)
    idle(20);
    `CHK("a_load", 16'h1234, ra)
    rd(`STC_ADDR_A_HI, 8'h12);
    rd(`STC_ADDR_STAT, 8'h00);
    wr(`STC_ADDR_B_LO, 8'h67);
    wr(`STC_ADDR_B_HI, 8'h05);
    idle(20);
    `CHK("b_refused", 16'hffff, rb)
    wr(`STC_ADDR_CTRL, 8'h0b);
    wr(`STC_ADDR_CTRL_ALIAS, 8'h8b);
    idle(1);
    `CHK("tff_ppg", 1'b1, tff)
    wr(`STC_ADDR_B_LO, 8'h67);
    wr(`STC_ADDR_B_HI, 8'h05);
    idle(20);
    `CHK("b_load", 16'h0567, rb)
    rd(`STC_ADDR_B_LO, 8'h67);
    wr(`STC_ADDR_CTRL, 8'h08);
    idle(1);
    `CHK("tff_off", 1'b0, tff)
    up_count_i <= 16'h5a5a;
    wr(`STC_ADDR_CTRL, 8'h58);
    idle(20);
    `CHK("acap", 1'b1, acap)
    `CHK("capture", 16'h5a5a, rb)
    rd(`STC_ADDR_B_LO, 8'h5a);
    rd(`STC_ADDR_STAT, 8'h04);
    @(posedge ref_clk_i);
    stop_enter_i <= 1;
    @(posedge ref_clk_i);
    stop_enter_i <= 0;
    #1 `CHK("stop_start", 2'h0, start)
    rd(`STC_ADDR_CTRL, 8'h48);
    rd(`STC_ADDR_CTRL_ALIAS, 8'h48);
    idle(2);
    `CHK("acap_stop", 1'b0, acap)
    wr(`STC_ADDR_CTRL, 8'h58);
    idle(1);
    `CHK("restart", 2'h1, start)
    rd(8'h20, 8'h00);
    conclude;
  end
endmodule // stc_timer_ctrl_tb_top
`default_nettype wire
